// [core/gated_pulse_width_counter.sv]
// Gated pulse width counter with Avalon-MM register slave and masked interrupt
//
// Function
// [RULE1] Counter advances on each falling edge of measured input ANDed with source clock.
// [RULE2] Software selects an internal source and keeps dual-edge counting at zero.
// [RULE3] Interrupt on measured input falling edge, or both edges when selected.
// [RULE4] Software reads count while input low, then clears it, usually in handler.
// [RULE5] Without a clear, the next high period resumes from the held count.
// [RULE6] Wrap from all ones to zero sets the overflow flag.
// [RULE7] Overflow flag holds until software clears the counter.
// [RULE8] Writing stop code while input high raises a timer interrupt.
// [RULE9] Software masks interrupts around a stop and clears the pending latch.
// [RULE10] Start with both-edge interrupts and input high raises an interrupt at once.
// [RULE11] Input falling while source clock high yields one extra count.
// [RULE12] Counter clear resets the count to zero.
`timescale 1ns/1ps

module gated_pulse_width_counter
  import pwm_meas_pkg::*;
#(
  parameter int CNT_W   = 18,
  parameter int PRESC_W = 8
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              measured_input_pin,
  output logic                   timer_irq
);

  localparam logic [CNT_W-1:0]   CNT_ONE   = CNT_W'(1);
  localparam logic [CNT_W-1:0]   CNT_MAX   = {CNT_W{1'b1}};
  localparam logic [PRESC_W-1:0] PRESC_ONE = PRESC_W'(1);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Low address bits are ignored so any byte within a word hits it
  function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
    word_addr = {a[ADDR_W-1:2], 2'b00};
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic              ack_q,       ack_d;
  logic [DATA_W-1:0] readdata_q,  readdata_d;
  logic [1:0]        run_q,       run_d;
  logic [2:0]        src_sel_q,   src_sel_d;
  logic              dual_q,      dual_d;
  logic              edge_q,      edge_d;
  logic [IRQ_W-1:0]  irq_stat_q,  irq_stat_d;
  logic [IRQ_W-1:0]  irq_mask_q,  irq_mask_d;
  logic              irq_q,       irq_d;
  logic              meas_s1_q,   meas_s2_q,  meas_s3_q;
  logic [PRESC_W-1:0] presc_q,    presc_d;
  logic              and_q,       and_d;
  logic [CNT_W-1:0]  count_q,     count_d;
  logic              ovf_q,       ovf_d;

  logic              req;
  logic              wr_take;
  logic [ADDR_W-1:0] waddr;
  logic              wr_ctrl_a;
  logic              clr_pulse;
  logic              start_wr;
  logic              stop_wr;
  logic              running;
  logic              src_clk;
  logic              and_now;
  logic              inc;
  logic              wrap;
  logic              meas_rise;
  logic              meas_fall;
  logic              tmr_evt;
  logic [IRQ_W-1:0]  w1c;

  // ------------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------------
  // One wait cycle per access: read data is registered from the first
  // cycle, so it stands at the edge where waitrequest is low.
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = readdata_q;
  assign wr_take         = avs_write & ack_q;
  assign waddr           = word_addr(avs_address);
  assign wr_ctrl_a       = wr_take & (waddr == OFF_TIMER_CTRL_REG_A);
  assign clr_pulse       = wr_ctrl_a & avs_writedata[CA_CLEAR_BIT];
  assign start_wr        = wr_ctrl_a & (avs_writedata[CA_RUN_LSB +: 2] == RUN_START);
  assign stop_wr         = wr_ctrl_a & (avs_writedata[CA_RUN_LSB +: 2] == RUN_STOP);

  always_comb
  begin
    ack_d      = req & ~ack_q;
    readdata_d = readdata_q;
    run_d      = run_q;
    src_sel_d  = src_sel_q;
    dual_d     = dual_q;
    edge_d     = edge_q;
    irq_mask_d = irq_mask_q;
    w1c        = '0;
    if (avs_read && !ack_q)
    begin
      readdata_d = '0;
      case (waddr)
        OFF_TIMER_CTRL_REG_A:
        begin
          readdata_d[CA_RUN_LSB +: 2] = run_q;
          readdata_d[CA_SRC_LSB +: 3] = src_sel_q;
        end
        OFF_TIMER_CTRL_REG_B:
        begin
          readdata_d[CB_DUAL_BIT] = dual_q;
          readdata_d[CB_EDGE_BIT] = edge_q;
        end
        OFF_COUNT_VALUE_REG:
        begin
          readdata_d[CNT_W-1:0] = count_q;
        end
        OFF_TIMER_STATUS_REG:
        begin
          readdata_d[ST_OVF_BIT] = ovf_q;
          readdata_d[ST_PIN_BIT] = meas_s2_q;
          readdata_d[ST_RUN_BIT] = running;
        end
        OFF_IRQ_STATUS_REG:
        begin
          readdata_d[IRQ_W-1:0] = irq_stat_q;
        end
        OFF_IRQ_MASK_REG:
        begin
          readdata_d[IRQ_W-1:0] = irq_mask_q;
        end
        default:
        begin
          readdata_d = '0;
        end
      endcase
    end
    if (wr_take)
    begin
      case (waddr)
        OFF_TIMER_CTRL_REG_A:
        begin
          run_d     = avs_writedata[CA_RUN_LSB +: 2];
          src_sel_d = avs_writedata[CA_SRC_LSB +: 3];
        end
        OFF_TIMER_CTRL_REG_B:
        begin
          dual_d = avs_writedata[CB_DUAL_BIT];
          edge_d = avs_writedata[CB_EDGE_BIT];
        end
        OFF_IRQ_STATUS_REG:
        begin
          w1c = avs_writedata[IRQ_W-1:0];
        end
        OFF_IRQ_MASK_REG:
        begin
          irq_mask_d = avs_writedata[IRQ_W-1:0];
        end
        default:
        begin
          w1c = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ack_q      <= 1'b0;
      readdata_q <= '0;
      run_q      <= RUN_RST;
      src_sel_q  <= SRC_RST;
      dual_q     <= DUAL_RST;
      edge_q     <= EDGE_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end
    else
    begin
      ack_q      <= ack_d;
      readdata_q <= readdata_d;
      run_q      <= run_d;
      src_sel_q  <= src_sel_d;
      dual_q     <= dual_d;
      edge_q     <= edge_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // ------------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------------
  // Stage one feeds stage two only; the third stage is for edge detect
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meas_s1_q <= 1'b0;
      meas_s2_q <= 1'b0;
      meas_s3_q <= 1'b0;
    end
    else
    begin
      meas_s1_q <= measured_input_pin;
      meas_s2_q <= meas_s1_q;
      meas_s3_q <= meas_s2_q;
    end
  end

  // ------------------------------------------------------------------
  // Gated counter
  // ------------------------------------------------------------------
  // Source clock is a prescaler tap; tap n divides sys_clk by 2^(n+1).
  // Dual-edge counting is stored only: this mode counts falling edges.
  assign running   = (run_q == RUN_START);
  assign src_clk   = presc_q[src_sel_q];
  assign and_now   = meas_s2_q & src_clk;
  assign inc       = running & and_q & ~and_now;                  // [RULE1] [RULE11]
  assign wrap      = inc & (count_q == CNT_MAX);                  // [RULE6]
  assign meas_rise = meas_s2_q & ~meas_s3_q;
  assign meas_fall = ~meas_s2_q & meas_s3_q;

  always_comb
  begin
    presc_d = presc_q + PRESC_ONE;
    and_d   = and_now;
    count_d = count_q;                                            // [RULE5]
    if (clr_pulse)
    begin
      count_d = '0;                                               // [RULE12]
    end
    else if (inc)
    begin
      count_d = count_q + CNT_ONE;                                // [RULE1]
    end
    // A wrap in the clearing cycle still leaves the flag set
    ovf_d = wrap | (ovf_q & ~clr_pulse);                          // [RULE6] [RULE7]
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      presc_q <= '0;
      and_q   <= 1'b0;
      count_q <= '0;
      ovf_q   <= 1'b0;
    end
    else
    begin
      presc_q <= presc_d;
      and_q   <= and_d;
      count_q <= count_d;
      ovf_q   <= ovf_d;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------------
  assign tmr_evt = (running & (meas_fall | (edge_q & meas_rise)))  // [RULE3]
                 | (stop_wr & meas_s2_q)                           // [RULE8]
                 | (start_wr & edge_q & meas_s2_q);                // [RULE10]

  always_comb
  begin
    irq_stat_d              = irq_stat_q & ~w1c;
    irq_stat_d[IRQ_TMR_BIT] = tmr_evt | irq_stat_d[IRQ_TMR_BIT];  // [RULE3]
    irq_stat_d[IRQ_OVF_BIT] = wrap | irq_stat_d[IRQ_OVF_BIT];
    irq_d                   = |(irq_stat_q & irq_mask_q);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      irq_stat_q <= IRQ_STAT_RST;
      irq_q      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_q      <= irq_d;
    end
  end

  assign timer_irq = irq_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  count_step_a: assert property ((inc && !clr_pulse) // [RULE1]
                                 |=> count_q == $past(count_q) + CNT_ONE)
    else $error("count did not step on gated falling edge");

  count_hold_a: assert property ((!inc && !clr_pulse) |=> count_q == $past(count_q)) // [RULE5]
    else $error("count changed without gated edge");

  extra_count_a: assert property ((running && and_q && !meas_s2_q && !clr_pulse) // [RULE11]
                                  |=> count_q == $past(count_q) + CNT_ONE)
    else $error("no extra count when input fell with source high");

  fall_irq_a: assert property ((running && meas_fall) |=> irq_stat_q[IRQ_TMR_BIT]) // [RULE3]
    else $error("falling edge did not raise timer event");

  // The output is registered, so it follows the mask of the cycle before
  both_irq_a: assert property ((running && edge_q && meas_rise) // [RULE3]
                               |=> irq_stat_q[IRQ_TMR_BIT]
                               ##1 (timer_irq || !$past(irq_mask_q[IRQ_TMR_BIT])))
    else $error("rising edge in both-edge mode lost");

  rise_quiet_a: assert property ((running && !edge_q && meas_rise && !stop_wr // [RULE3]
                                  && !start_wr && !irq_stat_q[IRQ_TMR_BIT])
                                 |=> !irq_stat_q[IRQ_TMR_BIT])
    else $error("rising edge raised event in falling-only mode");

  wrap_ovf_a: assert property ((wrap && !clr_pulse) |=> ovf_q && count_q == '0) // [RULE6]
    else $error("wrap did not set overflow flag");

  ovf_hold_a: assert property ((ovf_q && !clr_pulse) |=> ovf_q [*1]) // [RULE7]
    else $error("overflow flag dropped without clear");

  ovf_clear_a: assert property ((clr_pulse && !wrap) // [RULE7] [RULE12]
                                |=> !ovf_q && count_q == '0)
    else $error("clear did not reset count and flag");

  stop_irq_a: assert property ((stop_wr && meas_s2_q) // [RULE8]
                               |=> irq_stat_q[IRQ_TMR_BIT] && !running)
    else $error("stop write while input high raised no event");

  start_irq_a: assert property ((start_wr && edge_q && meas_s2_q) // [RULE10]
                                |=> irq_stat_q[IRQ_TMR_BIT] && running)
    else $error("start in both-edge mode with input high raised no event");

  bus_wait_a: assert property ((req && avs_waitrequest) |=> !avs_waitrequest || !req)
    else $error("waitrequest held longer than one cycle");

  wrap_cov: cover property (wrap);
  both_edge_cov: cover property (running && edge_q && meas_rise);
  clear_cov: cover property (clr_pulse && ovf_q);
  irq_cov: cover property (timer_irq);

endmodule // gated_pulse_width_counter

// [core/pwm_meas_pkg.sv]
// Package: register map, field layout and reset values of the gated pulse width counter
package pwm_meas_pkg;

  // ------------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_TIMER_CTRL_REG_A    = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_TIMER_CTRL_REG_B    = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT_VALUE_REG     = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_TIMER_STATUS_REG    = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS_REG      = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK_REG        = 5'h14;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CA_RUN_LSB    = 0;  // run_stop_ctrl, 2 bits
  localparam int CA_CLEAR_BIT  = 2;  // counter_clear_ctrl, write one, reads zero
  localparam int CA_SRC_LSB    = 3;  // source_clock_select, 3 bits
  localparam int CB_DUAL_BIT   = 0;  // dual_edge_count_select
  localparam int CB_EDGE_BIT   = 1;  // irq_edge_select: 0 falling, 1 both
  localparam int ST_OVF_BIT    = 0;  // overflow_flag
  localparam int ST_PIN_BIT    = 1;  // synchronised measured input level
  localparam int ST_RUN_BIT    = 2;  // counter running
  localparam int IRQ_TMR_BIT   = 0;  // timer_irq event (pending timer latch)
  localparam int IRQ_OVF_BIT   = 1;  // wrap-around event
  localparam int IRQ_W         = 2;

  // ------------------------------------------------------------------
  // Codes and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] RUN_STOP  = 2'h0;
  localparam logic [1:0] RUN_START = 2'h2;
  localparam logic [1:0] RUN_RST   = 2'h0;
  localparam logic [2:0] SRC_RST   = 3'h0;
  localparam logic       DUAL_RST  = 1'b0;
  localparam logic       EDGE_RST  = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_STAT_RST = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

endpackage

// [verif/pulse_source.sv]
// Model of the external pulse that drives the measured input pin
`timescale 1ns/1ps

module pulse_source
(
  input  wire logic sys_clk,
  output logic      pulse_out
);
  // ------------------------------------------------------------------
  // Drive
  // ------------------------------------------------------------------
  initial pulse_out = 1'b0;

  // Level is changed right after an edge, then held for a number of cycles
  task automatic drive(input logic level, input int cycles);
    pulse_out <= level;
    repeat (cycles) @(posedge sys_clk);
  endtask

  // Low tail leaves time for the two-flop synchroniser and the event flags
  task automatic pulse(input int high_cycles);
    drive(1'b1, high_cycles);
    drive(1'b0, 10);
  endtask
endmodule // pulse_source

// [verif/test_gated_pulse_width_counter.sv]
// Self-checking testbench of the gated pulse width counter
`timescale 1ns/1ps

module test_gated_pulse_width_counter
  import pwm_meas_pkg::*;
;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  // Short counter so that wrap-around fits in the run
  localparam int CW = 8;
  typedef struct {logic [ADDR_W-1:0] addr; logic [31:0] wd; logic [31:0] exp;} row_s;
  logic              sys_clk;
  logic              rst;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              measured_input_pin;
  logic              timer_irq;
  logic [31:0]       rd;
  logic [31:0]       c1;
  int                err_total;
  int                comparisons;
  row_s              rows[8] = '{
    '{OFF_TIMER_CTRL_REG_B, 32'h3, 32'h3}, '{OFF_TIMER_CTRL_REG_B, 32'hffffffff, 32'h3},
    '{OFF_IRQ_MASK_REG, 32'hffffffff, 32'h3}, '{5'h18, 32'hffffffff, 32'h0},
    '{OFF_TIMER_CTRL_REG_A, 32'h3c, 32'h38}, '{OFF_COUNT_VALUE_REG, 32'hff, 32'h0},
    '{OFF_TIMER_CTRL_REG_B, 32'h0, 32'h0}, '{OFF_IRQ_MASK_REG, 32'h1, 32'h1}};

  gated_pulse_width_counter #(.CNT_W(CW), .PRESC_W(8)) i_gated_pulse_width_counter (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .measured_input_pin(measured_input_pin),
    .timer_irq(timer_irq));

  pulse_source i_pulse_source (.sys_clk(sys_clk), .pulse_out(measured_input_pin));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic in_range(input logic [31:0] seen, input int lo, input int hi);
    check({31'h0, (seen >= lo) && (seen <= hi)}, 32'h1);
  endtask

  // One request, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50)
    begin
      err_total++;
      tally_and_finish();
    end
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic wait_irq(input logic exp);
    repeat (3) @(posedge sys_clk);
    check({31'h0, timer_irq}, {31'h0, exp});
  endtask

  // ------------------------------------------------------------------
  // Clock and sequence
  // ------------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial
  begin
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    err_total = 0;
    comparisons = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    check({31'h0, timer_irq}, 32'h0);
    rd_chk(OFF_TIMER_CTRL_REG_A, 32'h0);
    rd_chk(OFF_TIMER_STATUS_REG, 32'h0);
    rd_chk(OFF_IRQ_STATUS_REG, 32'h0);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].addr, rows[i].wd);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    // Clear and start on tap 0: one count per two cycles of high input
    bus(1'b1, OFF_TIMER_CTRL_REG_A, 32'h6);
    rd_chk(OFF_TIMER_STATUS_REG, 32'h4);
    i_pulse_source.pulse(40);
    bus(1'b0, OFF_COUNT_VALUE_REG, 32'h0);
    c1 = rd;
    in_range(c1, 19, 21);
    rd_chk(OFF_IRQ_STATUS_REG, 32'h1);
    wait_irq(1'b1);
    i_pulse_source.pulse(40);
    bus(1'b0, OFF_COUNT_VALUE_REG, 32'h0);
    in_range(rd - c1, 19, 21);
    bus(1'b1, OFF_IRQ_STATUS_REG, 32'h1);
    rd_chk(OFF_IRQ_STATUS_REG, 32'h0);
    wait_irq(1'b0);
    bus(1'b1, OFF_TIMER_CTRL_REG_A, 32'h6);
    rd_chk(OFF_COUNT_VALUE_REG, 32'h0);
    // Wrap past all ones of the shortened counter
    i_pulse_source.pulse(600);
    bus(1'b0, OFF_COUNT_VALUE_REG, 32'h0);
    in_range(rd, 299 - (1 << CW), 301 - (1 << CW));
    rd_chk(OFF_TIMER_STATUS_REG, 32'h5);
    rd_chk(OFF_IRQ_STATUS_REG, 32'h3);
    i_pulse_source.pulse(20);
    rd_chk(OFF_TIMER_STATUS_REG, 32'h5);
    bus(1'b1, OFF_TIMER_CTRL_REG_A, 32'h6);
    rd_chk(OFF_TIMER_STATUS_REG, 32'h4);
    rd_chk(OFF_COUNT_VALUE_REG, 32'h0);
    // Tap 2 divides by eight: one count per eight cycles of high input
    bus(1'b1, OFF_TIMER_CTRL_REG_A, 32'h16);
    i_pulse_source.pulse(64);
    bus(1'b0, OFF_COUNT_VALUE_REG, 32'h0);
    in_range(rd, 7, 9);
    bus(1'b1, OFF_IRQ_STATUS_REG, 32'h3);
    rd_chk(OFF_IRQ_STATUS_REG, 32'h0);
    // Both edges: rising input raises an event too
    bus(1'b1, OFF_TIMER_CTRL_REG_B, 32'h2);
    i_pulse_source.drive(1'b1, 8);
    rd_chk(OFF_IRQ_STATUS_REG, 32'h1);
    bus(1'b1, OFF_IRQ_STATUS_REG, 32'h1);
    // Safe stop while input is high: mask, stop, clear latch, unmask
    bus(1'b1, OFF_IRQ_MASK_REG, 32'h0);
    bus(1'b1, OFF_TIMER_CTRL_REG_A, 32'h0);
    repeat (3) @(posedge sys_clk);
    rd_chk(OFF_IRQ_STATUS_REG, 32'h1);
    wait_irq(1'b0);
    bus(1'b1, OFF_IRQ_STATUS_REG, 32'h1);
    bus(1'b1, OFF_IRQ_MASK_REG, 32'h1);
    wait_irq(1'b0);
    // Start with both edges selected and input already high
    bus(1'b1, OFF_TIMER_CTRL_REG_A, 32'h2);
    repeat (3) @(posedge sys_clk);
    rd_chk(OFF_IRQ_STATUS_REG, 32'h1);
    wait_irq(1'b1);
    // Mid-run reset with the input still high returns all to idle
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check({31'h0, timer_irq}, 32'h0);
    rd_chk(OFF_TIMER_CTRL_REG_A, 32'h0);
    rd_chk(OFF_COUNT_VALUE_REG, 32'h0);
    rd_chk(OFF_IRQ_STATUS_REG, 32'h0);
    tally_and_finish();
  end
endmodule // test_gated_pulse_width_counter
